/* File: hdl/emb_consts.svh */
// Contract
// - reset pin high two machine cycles resets
// - latch pulse steady at oscillator over six
// - one latch pulse dropped per data access
// - latch disable bit limits pulse, weak pullup
// - latch disable ignored in external execution
// - two fetch strobes per cycle, skipped on data
// - low address byte presented with latch pulse
// - low port multiplexes address and data
// - high address driven for fetch and pointer
// - register-indirect access drives port latch value
// - source select low external, high internal
// - lock bit freezes source select at reset
// - port3 bit6 write, bit7 read strobes
`ifndef EMB_CONSTS_SVH
`define EMB_CONSTS_SVH

// machine cycle of twelve oscillator periods, six two-clock states
`define EMB_PHASES       4'd12
`define EMB_LAST_PHASE   4'd11
`define EMB_ALE1_PHASE   4'd0
`define EMB_ALE2_PHASE   4'd6
`define EMB_ALE_WIDTH    4'd2
`define EMB_ADDR_WIDTH   4'd3
`define EMB_STB1_FIRST   4'd3
`define EMB_STB1_LAST    4'd5
`define EMB_STB2_FIRST   4'd9
`define EMB_STB2_LAST    4'd10
`define EMB_XSTB_FIRST   4'd3
`define EMB_XSTB_LAST    4'd9
`define EMB_CAP1_PHASE   4'd7
`define EMB_CAP2_PHASE   4'd0
`define EMB_XCAP_PHASE   4'd11
// reset pin hold: two machine cycles in oscillator periods
`define EMB_RST_MCYCLES  6'd2
`define EMB_RST_CLKS     6'd24
`define EMB_SETTLE_CLKS  2'd3

`endif

/* File: hdl/emb_pkg.sv */
package emb_pkg;

    typedef enum logic [1:0] {
        EMB_CMD_NONE = 2'b00,
        EMB_CMD_XRD  = 2'b01,
        EMB_CMD_XWR  = 2'b10
    } emb_cmd_e;

    typedef enum logic [1:0] {
        EMB_DATA_CODE1 = 2'b00,
        EMB_DATA_CODE2 = 2'b01,
        EMB_DATA_XRD   = 2'b10
    } emb_kind_e;

    // one machine cycle worth of work from the core
    typedef struct packed {
        emb_cmd_e    cmd;
        logic [15:0] addr;
        logic [7:0]  wdata;
        logic        ptr16;
        logic        table_rd;
    } emb_req_s;

    typedef struct packed {
        logic       ale;
        logic       ale_oe;
        logic       code_fetch_strobe_n;
        logic       wr_n;
        logic       rd_n;
        logic [7:0] lo_o;
        logic       lo_oe;
        logic [7:0] hi_o;
    } emb_pins_s;

    typedef struct packed {
        logic [3:0]  phase;
        emb_req_s    req;
        logic [15:0] fetch_addr;
        logic        ale_dis;
        logic        last_fetch;
        logic [1:0]  rst_sync;
        logic [1:0]  src_sync;
        logic [1:0]  lock_sync;
        logic [15:0] lo_sync;
        logic [5:0]  rst_cnt;
        logic [1:0]  settle;
        logic        caught;
        logic        src_latched;
        emb_pins_s   pins;
        logic [7:0]  rdata;
        emb_kind_e   rkind;
        logic        rvalid;
    } emb_state_s;

endpackage : emb_pkg

/* File: hdl/emb_bus_port.sv */
`timescale 1ns/100ps
`default_nettype none
`include "emb_consts.svh"

module emb_bus_port (
    input  wire logic                clk,
    input  wire logic                arst_n,
    // reset pin, active high, asynchronous to clk
    input  wire logic                rst_pin,
    // code source select strap: low external, high internal
    input  wire logic                code_source_select,
    input  wire logic                lock_bit1,
    // core side
    input  wire emb_pkg::emb_req_s   req,
    input  wire logic                req_valid,
    output logic                     req_ready,
    input  wire logic [15:0]         fetch_addr,
    input  wire logic [7:0]          high_port_latch,
    input  wire logic                ale_disable,
    output logic                     ext_exec,
    output logic                     bus_reset,
    output logic [7:0]               rdata,
    output emb_pkg::emb_kind_e       rkind,
    output logic                     rvalid,
    // pins
    output logic                     ale,
    output logic                     ale_oe,
    output logic                     code_fetch_strobe_n,
    output logic                     wr_strobe_n,
    output logic                     rd_strobe_n,
    input  wire logic [7:0]          low_addr_data_port_i,
    output logic [7:0]               low_addr_data_port_o,
    output logic                     low_addr_data_port_oe,
    output logic [7:0]               high_addr_port
);

    emb_pkg::emb_state_s s;
    emb_pkg::emb_state_s next_s;

    // derived views of the current machine cycle
    logic       src_level;
    logic       ext;
    logic       xd;
    logic       xrd;
    logic       xwr;
    logic       in_ale;
    logic       ale_ok;
    logic       addr_ph;
    logic       stb_ph;
    logic       xstb_ph;
    logic [7:0] lo_sample;
    logic [15:0] fetch2;

    // source select is frozen at reset when the lock bit is set
    always_comb begin
        src_level = s.lock_sync[1] ? s.src_latched : s.src_sync[1];
    end

    // mode decode; strap low means every fetch goes off chip
    always_comb begin
        ext     = ~src_level;
        xd      = (s.req.cmd != emb_pkg::EMB_CMD_NONE);
        xrd     = (s.req.cmd == emb_pkg::EMB_CMD_XRD);
        xwr     = (s.req.cmd == emb_pkg::EMB_CMD_XWR);
        fetch2  = s.fetch_addr + 16'h0001;
        lo_sample = s.lo_sync[15:8];
    end

    // phase windows, all fixed by oscillator count with no wait input
    always_comb begin
        in_ale = (s.phase >= `EMB_ALE1_PHASE &&
                  s.phase < `EMB_ALE1_PHASE + `EMB_ALE_WIDTH) ||
                 (!xd && s.phase >= `EMB_ALE2_PHASE &&
                  s.phase < `EMB_ALE2_PHASE + `EMB_ALE_WIDTH);
        addr_ph = (s.phase < `EMB_ADDR_WIDTH) ||
                  (!xd && s.phase >= `EMB_ALE2_PHASE &&
                   s.phase < `EMB_ALE2_PHASE + `EMB_ADDR_WIDTH);
        stb_ph = (s.phase >= `EMB_STB1_FIRST &&
                  s.phase <= `EMB_STB1_LAST) ||
                 (s.phase >= `EMB_STB2_FIRST &&
                  s.phase <= `EMB_STB2_LAST);
        xstb_ph = (s.phase >= `EMB_XSTB_FIRST &&
                   s.phase <= `EMB_XSTB_LAST);
        // the disable bit only bites in internal execution
        ale_ok = !s.ale_dis || ext || xd || s.req.table_rd;
    end

    // core takes a new request on the last phase of each machine cycle
    always_comb begin
        req_ready = (s.phase == `EMB_LAST_PHASE) && !bus_reset;
    end

    // next state
    always_comb begin
        next_s = s;
        next_s.rvalid = 1'b0;

        // two-flop synchronisers for every pin input
        next_s.rst_sync  = {s.rst_sync[0], rst_pin};
        next_s.src_sync  = {s.src_sync[0], code_source_select};
        next_s.lock_sync = {s.lock_sync[0], lock_bit1};
        next_s.lo_sync   = {s.lo_sync[7:0], low_addr_data_port_i};

        // machine cycle phase counter
        if (s.phase == `EMB_LAST_PHASE) begin
            next_s.phase = 4'h0;
        end else begin
            next_s.phase = s.phase + 4'h1;
        end

        // request hand-off at the cycle boundary
        if (req_ready) begin
            next_s.req        = req_valid ? req : '0;
            next_s.fetch_addr = fetch_addr;
            next_s.ale_dis    = ale_disable;
            next_s.last_fetch = ext && !xd;
        end

        // strap capture once the synchronisers have settled after reset
        if (s.settle != `EMB_SETTLE_CLKS) begin
            next_s.settle = s.settle + 2'h1;
        end else if (!s.caught) begin
            next_s.caught      = 1'b1;
            next_s.src_latched = s.src_sync[1];
        end

        // latch pulse: weak pullup when disabled, so the pin floats high
        next_s.pins.ale_oe = ale_ok;
        next_s.pins.ale    = ale_ok ? in_ale : 1'b1;

        // program fetch strobe, both skipped while a data access runs
        next_s.pins.code_fetch_strobe_n = !(ext && !xd && stb_ph);

        // data strobes on port 3 bits 6 and 7
        next_s.pins.wr_n = !(xwr && xstb_ph);
        next_s.pins.rd_n = !(xrd && xstb_ph);

        // low port: address during latch window, data after it
        next_s.pins.lo_oe = 1'b0;
        next_s.pins.lo_o  = 8'hff;
        if (addr_ph && (ext || xd)) begin
            next_s.pins.lo_oe = 1'b1;
            if (xd) begin
                next_s.pins.lo_o = s.req.addr[7:0];
            end else if (s.phase < `EMB_ALE2_PHASE) begin
                next_s.pins.lo_o = s.fetch_addr[7:0];
            end else begin
                next_s.pins.lo_o = fetch2[7:0];
            end
        end else if (xwr && s.phase >= `EMB_XSTB_FIRST) begin
            // actively driven, internal pullups stand in for open drain
            next_s.pins.lo_oe = 1'b1;
            next_s.pins.lo_o  = s.req.wdata;
        end

        // high port: pointer or fetch address, else the port latch
        if (xd && s.req.ptr16) begin
            next_s.pins.hi_o = s.req.addr[15:8];
        end else if (xd) begin
            next_s.pins.hi_o = high_port_latch;
        end else if (ext) begin
            if (s.phase < `EMB_ALE2_PHASE) begin
                next_s.pins.hi_o = s.fetch_addr[15:8];
            end else begin
                next_s.pins.hi_o = fetch2[15:8];
            end
        end else begin
            next_s.pins.hi_o = high_port_latch;
        end

        // read captures; synchroniser adds two clocks of lag to the pin
        if (ext && !xd && s.phase == `EMB_CAP1_PHASE) begin
            next_s.rdata  = lo_sample;
            next_s.rkind  = emb_pkg::EMB_DATA_CODE1;
            next_s.rvalid = 1'b1;
        end else if (s.last_fetch && s.phase == `EMB_CAP2_PHASE) begin
            next_s.rdata  = lo_sample;
            next_s.rkind  = emb_pkg::EMB_DATA_CODE2;
            next_s.rvalid = 1'b1;
        end else if (xrd && s.phase == `EMB_XCAP_PHASE) begin
            next_s.rdata  = lo_sample;
            next_s.rkind  = emb_pkg::EMB_DATA_XRD;
            next_s.rvalid = 1'b1;
        end

        // reset pin held long enough: full reset of the bus side
        if (s.rst_sync[1]) begin
            if (s.rst_cnt != `EMB_RST_CLKS) begin
                next_s.rst_cnt = s.rst_cnt + 6'h01;
            end
        end else begin
            next_s.rst_cnt = 6'h00;
        end
        if (bus_reset) begin
            next_s.phase       = 4'h0;
            next_s.req         = '0;
            next_s.fetch_addr  = 16'h0000;
            next_s.ale_dis     = 1'b0;
            next_s.last_fetch  = 1'b0;
            next_s.caught      = 1'b0;
            next_s.settle      = 2'h0;
            next_s.pins.ale    = 1'b0;
            next_s.pins.ale_oe = 1'b1;
            next_s.pins.code_fetch_strobe_n = 1'b1;
            next_s.pins.wr_n   = 1'b1;
            next_s.pins.rd_n   = 1'b1;
            next_s.pins.lo_o   = 8'hff;
            next_s.pins.lo_oe  = 1'b0;
            next_s.pins.hi_o   = 8'hff;
            next_s.rvalid      = 1'b0;
        end
    end

    // bus reset once the pin has stood high two machine cycles
    always_comb begin
        bus_reset = (s.rst_cnt == `EMB_RST_CLKS);
    end

    // state register, constants only under the asynchronous reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s             <= '0;
            s.src_sync    <= 2'h3;
            s.src_latched <= 1'b1;
            s.pins.ale_oe <= 1'b1;
            s.pins.code_fetch_strobe_n <= 1'b1;
            s.pins.wr_n   <= 1'b1;
            s.pins.rd_n   <= 1'b1;
            s.pins.lo_o   <= 8'hff;
            s.pins.hi_o   <= 8'hff;
        end else begin
            s <= next_s;
        end
    end

    // outputs straight from the state flops, ext_exec decoded from them
    always_comb begin
        ext_exec              = ext;
        rdata                 = s.rdata;
        rkind                 = s.rkind;
        rvalid                = s.rvalid;
        ale                   = s.pins.ale;
        ale_oe                = s.pins.ale_oe;
        code_fetch_strobe_n   = s.pins.code_fetch_strobe_n;
        wr_strobe_n           = s.pins.wr_n;
        rd_strobe_n           = s.pins.rd_n;
        low_addr_data_port_o  = s.pins.lo_o;
        low_addr_data_port_oe = s.pins.lo_oe;
        high_addr_port        = s.pins.hi_o;
    end

endmodule : emb_bus_port

`default_nettype wire

/* File: verification/emb_bus_port_monitor.sv */
`timescale 1ns/100ps
`default_nettype none
module emb_bus_monitor (
    input wire logic       clk,
    input wire logic       arst_n,
    input wire logic       ext_exec,
    input wire logic       bus_reset,
    input wire logic       ale,
    input wire logic       ale_oe,
    input wire logic       code_fetch_strobe_n,
    input wire logic       wr_strobe_n,
    input wire logic       rd_strobe_n,
    input wire logic [7:0] low_addr_data_port_o,
    input wire logic       low_addr_data_port_oe
);
    default clocking @(posedge clk); endclocking
    // a pin reset freezes the bus, so it masks the timing checks
    default disable iff (!arst_n || bus_reset);

    // latch pulse: two clocks wide, six apart, twelve over a data access
    // a rise into the disabled (weakly pulled high) level is not a pulse
    property p_ale_per; $rose(ale) && ale_oe |=> ale ##1 !ale [*4];
    endproperty
    a_ale_per: assert property (p_ale_per) else $error("ale width");
    property p_ale_nxt; $rose(ale) && ext_exec |-> ##[6:12] $rose(ale);
    endproperty
    a_ale_nxt: assert property (p_ale_nxt) else $error("ale gap");
    property p_wr_skip; $fell(wr_strobe_n) |-> !ale [*7]; endproperty
    a_wr_skip: assert property (p_wr_skip) else $error("ale in wr");
    // data strobes exclude fetch strobes and set the port direction
    property p_no_cfs; !(wr_strobe_n && rd_strobe_n) |-> code_fetch_strobe_n;
    endproperty
    a_no_cfs: assert property (p_no_cfs) else $error("fetch in data");
    property p_rd_dir; !rd_strobe_n |-> !low_addr_data_port_oe; endproperty
    a_rd_dir: assert property (p_rd_dir) else $error("rd drive");
    // external execution drives the port and holds the address across the pulse
    property p_addr; $rose(ale) && ext_exec |-> low_addr_data_port_oe ##1
        (low_addr_data_port_oe && $stable(low_addr_data_port_o)); endproperty
    a_addr: assert property (p_addr) else $error("addr hold");
    // released pin rests at the pullup level, never low
    property p_dis; !ale_oe |-> !ext_exec && ale; endproperty
    a_dis: assert property (p_dis) else $error("ale released");
    property p_rst; disable iff (!arst_n) bus_reset && $past(bus_reset) |->
        !ale && code_fetch_strobe_n && wr_strobe_n && rd_strobe_n; endproperty
    a_rst: assert property (p_rst) else $error("reset idle");

    c_wr: cover property ($fell(wr_strobe_n));
    c_rd: cover property ($fell(rd_strobe_n));
    c_dis: cover property (!ale_oe);
endmodule : emb_bus_monitor
`default_nettype wire

/* File: verification/emb_mem_model.sv */
`timescale 1ns/100ps
`default_nettype none
module emb_mem_model (
    input  wire logic        clk,
    input  wire logic        ale,
    input  wire logic        cfs_n,
    input  wire logic        rd_n,
    input  wire logic        wr_n,
    input  wire logic [7:0]  lo_o,
    input  wire logic        lo_oe,
    input  wire logic [7:0]  hi,
    output logic      [7:0]  pin,
    output logic      [23:0] wr_log
);
    logic [7:0] a_lo;
    // external latch follows the port while the pulse is high
    always @(posedge clk) a_lo <= ale ? lo_o : a_lo;
    // memory drives only under a strobe; port pullups give 1s otherwise
    always_comb begin
        if (lo_oe) pin = lo_o;
        else if (!cfs_n || !rd_n) pin = a_lo ^ hi ^ 8'h5a;
        else pin = 8'hff;
    end
    // last byte under the write strobe wins, as a real memory would
    always @(posedge clk) if (!wr_n) wr_log <= {hi, a_lo, pin};
endmodule : emb_mem_model
`default_nettype wire

/* File: verification/test_emb_bus_port.sv */
`timescale 1ns/100ps
`default_nettype none
module test_emb_bus_port;
    logic               clk, arst_n, rst_pin, code_source_select, lock_bit1;
    logic               req_valid, req_ready, ale_disable, ext_exec;
    logic               bus_reset, rvalid, ale, ale_oe, code_fetch_strobe_n;
    logic               wr_strobe_n, rd_strobe_n, low_addr_data_port_oe;
    logic [7:0]         high_port_latch, rdata, high_addr_port;
    logic [7:0]         low_addr_data_port_i, low_addr_data_port_o;
    logic [15:0]        fetch_addr;
    logic [23:0]        wr_log;
    emb_pkg::emb_req_s  req;
    emb_pkg::emb_kind_e rkind;
    int                 n_mismatch, total_checks, n_ale, n_cfs;

    emb_bus_port dut (.clk, .arst_n, .rst_pin, .code_source_select,
        .lock_bit1, .req, .req_valid, .req_ready, .fetch_addr,
        .high_port_latch, .ale_disable, .ext_exec, .bus_reset, .rdata,
        .rkind, .rvalid, .ale, .ale_oe, .code_fetch_strobe_n, .wr_strobe_n,
        .rd_strobe_n, .low_addr_data_port_i, .low_addr_data_port_o,
        .low_addr_data_port_oe, .high_addr_port);
    emb_mem_model mem (.clk, .ale, .cfs_n(code_fetch_strobe_n),
        .rd_n(rd_strobe_n), .wr_n(wr_strobe_n), .lo_o(low_addr_data_port_o),
        .lo_oe(low_addr_data_port_oe), .hi(high_addr_port),
        .pin(low_addr_data_port_i), .wr_log);

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    // pulse and strobe cycle counts for rate checks
    always @(posedge clk) begin
        if (ale) n_ale++;
        if (!code_fetch_strobe_n) n_cfs++;
    end

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    task automatic chk(input logic [23:0] got, exp, input string what);
        total_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: %s %h/%h", $time, what, got, exp);
        end
    endtask : chk
    task automatic finish_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : finish_test
    task automatic tmo();
        n_mismatch++;
        $display("unexpected at %0t: timeout", $time);
        finish_test();
    endtask : tmo
    // hand one machine cycle of work over at the ready phase
    task automatic issue(input emb_pkg::emb_cmd_e c, input logic [15:0] a,
                         input logic p);
        for (int i = 0; i < 30 && req_ready !== 1'b1; i++) step(1);
        if (req_ready !== 1'b1) tmo();
        req = '{c, a, 8'h9e, p, 1'b0};
        req_valid = 1'b1;
        step(1);
        req_valid = 1'b0;
    endtask : issue
    // other kinds keep arriving while fetching, so wait for this kind
    task automatic expect_rv(input emb_pkg::emb_kind_e k,
                             input logic [7:0] d);
        for (int i = 0; i < 40 && !(rvalid === 1'b1 && rkind === k); i++)
            step(1);
        if (rvalid !== 1'b1) tmo();
        chk({rkind, rdata}, {k, d}, "rdata");
        step(1);
    endtask : expect_rv

    task automatic t_fetch();
        fetch_addr = 16'h12a5;
        issue(emb_pkg::EMB_CMD_NONE, 16'h0000, 1'b0);
        expect_rv(emb_pkg::EMB_DATA_CODE1, 8'ha5 ^ 8'h12 ^ 8'h5a);
        expect_rv(emb_pkg::EMB_DATA_CODE2, 8'ha6 ^ 8'h12 ^ 8'h5a);
        n_ale = 0;
        step(24);
        chk(n_ale, 8, "ale rate");
        $display("t_fetch done");
    endtask : t_fetch
    task automatic t_xwr();
        issue(emb_pkg::EMB_CMD_XWR, 16'h3c71, 1'b1);
        n_ale = 0;
        step(12);
        chk(n_ale, 2, "ale skip");
        chk(wr_log, 24'h3c719e, "write");
        $display("t_xwr done");
    endtask : t_xwr
    task automatic t_xrd();
        issue(emb_pkg::EMB_CMD_XRD, 16'hbb33, 1'b0);
        expect_rv(emb_pkg::EMB_DATA_XRD, 8'h33 ^ 8'h47 ^ 8'h5a);
        $display("t_xrd done");
    endtask : t_xrd
    task automatic t_dis();
        ale_disable = 1'b1;
        issue(emb_pkg::EMB_CMD_NONE, 16'h0000, 1'b0);
        n_ale = 0;
        step(24);
        chk(n_ale, 8, "ale ext");
        ale_disable = 1'b0;
        issue(emb_pkg::EMB_CMD_NONE, 16'h0000, 1'b0);
        code_source_select = 1'b1;
        step(24);
        chk(ext_exec, 1'b0, "internal");
        ale_disable = 1'b1;
        issue(emb_pkg::EMB_CMD_NONE, 16'h0000, 1'b0);
        step(12);
        n_ale = 0;
        n_cfs = 0;
        step(24);
        // weak pullup holds the pin high for all 24 clocks, no fetches
        chk({ale_oe, n_ale[7:0], n_cfs[7:0]}, {1'b0, 8'd24, 8'd0},
            "quiet");
        issue(emb_pkg::EMB_CMD_XRD, 16'h0044, 1'b0);
        expect_rv(emb_pkg::EMB_DATA_XRD, 8'h44 ^ 8'h47 ^ 8'h5a);
        ale_disable = 1'b0;
        step(24);
        $display("t_dis done");
    endtask : t_dis
    task automatic t_lock();
        code_source_select = 1'b0;
        lock_bit1 = 1'b1;
        rst_pin = 1'b1;
        step(10);
        rst_pin = 1'b0;
        step(4);
        chk({bus_reset, ext_exec}, 2'b01, "short rst");
        rst_pin = 1'b1;
        step(40);
        chk(bus_reset, 1'b1, "rst");
        rst_pin = 1'b0;
        step(24);
        code_source_select = 1'b1;
        step(24);
        chk(ext_exec, 1'b1, "latched");
        lock_bit1 = 1'b0;
        step(12);
        chk(ext_exec, 1'b0, "live");
        $display("t_lock done");
    endtask : t_lock

    initial begin
        arst_n = 1'b0;
        rst_pin = 1'b0;
        code_source_select = 1'b0;
        lock_bit1 = 1'b0;
        req = '0;
        req_valid = 1'b0;
        fetch_addr = 16'h0000;
        high_port_latch = 8'h47;
        ale_disable = 1'b0;
        n_mismatch = 0;
        total_checks = 0;
        step(3);
        arst_n = 1'b1;
        t_fetch();
        t_xwr();
        t_xrd();
        t_dis();
        t_lock();
        finish_test();
    end
endmodule : test_emb_bus_port

bind emb_bus_port emb_bus_monitor u_mon (.clk, .arst_n, .ext_exec,
    .bus_reset, .ale, .ale_oe, .code_fetch_strobe_n, .wr_strobe_n,
    .rd_strobe_n, .low_addr_data_port_o, .low_addr_data_port_oe);
`default_nettype wire
